// file: logic/output_frequency_detector.sv
// output frequency detector: up-to-frequency and frequency-reached flags
// assumes frequency inputs come from logic on i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module output_frequency_detector
  import freq_detect_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [FREQ_W-1:0] i_out_freq,
  input wire logic [FREQ_W-1:0] i_cmd_freq,
  input wire logic i_reverse,
  input wire logic i_dc_brake,
  input wire logic [7:0] i_extended_display_select,
  input wire logic i_set_wr,
  input wire logic [1:0] i_set_sel,
  input wire logic [15:0] i_set_data,
  input wire logic [7:0] i_terminal_select_a,
  input wire logic [7:0] i_terminal_select_b,
  output logic [6:0] o_up_to_freq_sensitivity,
  output logic [15:0] o_forward_detect_level,
  output logic [15:0] o_reverse_detect_level,
  output logic o_up_to_freq_flag,
  output logic o_freq_reached_flag,
  output logic o_terminal_a,
  output logic o_terminal_b
);
  // ----------------------------------------
  // settings
  // ----------------------------------------
  logic [6:0] sens_q, sens_d;
  logic [15:0] fwd_q, fwd_d, rev_q, rev_d;
  logic [7:0] sel_a_q, sel_b_q;
  logic wr_ok;
  setting_sel_t sel;
  always_comb begin
    sens_d = sens_q;
    fwd_d = fwd_q;
    rev_d = rev_q;
    sel = setting_sel_t'(i_set_sel);
    wr_ok = i_set_wr && (i_extended_display_select == 8'h00);
    if (wr_ok) begin
      case (sel)
        SET_SENS: begin
          if (i_set_data <= {9'h000, SENS_MAX}) sens_d = i_set_data[6:0];
        end
        SET_FWD: begin
          if (i_set_data <= LEVEL_MAX) fwd_d = i_set_data;
        end
        SET_REV: begin
          if (i_set_data <= LEVEL_MAX || i_set_data == REV_SAME_CODE) rev_d = i_set_data;
        end
        default: begin
        end
      endcase
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      sens_q <= SENS_RESET;
      fwd_q <= FWD_LEVEL_RESET;
      rev_q <= REV_LEVEL_RESET;
      sel_a_q <= 8'h00;
      sel_b_q <= 8'h00;
    end else begin
      sens_q <= sens_d;
      fwd_q <= fwd_d;
      rev_q <= rev_d;
      sel_a_q <= i_terminal_select_a;
      sel_b_q <= i_terminal_select_b;
    end
  end
  // ----------------------------------------
  // comparisons
  // ----------------------------------------
  logic su_d, fu_d, su_q, fu_q;
  logic [15:0] level;
  logic [15:0] diff;
  logic [23:0] band;
  logic [23:0] diff_scaled;
  always_comb begin
    // i_out_freq is the uncompensated magnitude
    level = (i_reverse && rev_q != REV_SAME_CODE) ? rev_q : fwd_q;
    diff = (i_out_freq >= i_cmd_freq) ? 16'(i_out_freq - i_cmd_freq)
                                      : 16'(i_cmd_freq - i_out_freq);
    band = 24'(i_cmd_freq) * 24'(sens_q);
    diff_scaled = 24'(diff) * 24'd100;
    su_d = (diff_scaled <= band) && !i_dc_brake;
    fu_d = (i_out_freq >= level) && !i_dc_brake;
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      su_q <= 1'b0;
      fu_q <= 1'b0;
    end else begin
      su_q <= su_d;
      fu_q <= fu_d;
    end
  end
  // ----------------------------------------
  // terminal routing
  // ----------------------------------------
  term_route_if flags_if();
  assign flags_if.up_to_freq_flag = su_q;
  assign flags_if.freq_reached_flag = fu_q;
  logic term_a_d, term_b_d, term_a_q, term_b_q;
  term_router u_route_a (
    .i_code(sel_a_q),
    .flags(flags_if.sink),
    .o_conduct(term_a_d)
  );
  term_router u_route_b (
    .i_code(sel_b_q),
    .flags(flags_if.sink),
    .o_conduct(term_b_d)
  );
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      term_a_q <= 1'b0;
      term_b_q <= 1'b0;
    end else begin
      term_a_q <= term_a_d;
      term_b_q <= term_b_d;
    end
  end
  assign o_up_to_freq_sensitivity = sens_q;
  assign o_forward_detect_level = fwd_q;
  assign o_reverse_detect_level = rev_q;
  assign o_up_to_freq_flag = su_q;
  assign o_freq_reached_flag = fu_q;
  assign o_terminal_a = term_a_q;
  assign o_terminal_b = term_b_q;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  brake_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_dc_brake) |-> !su_q && !fu_q) else $error("flag set during dc brake");
  reach_fwd_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_dc_brake && !i_reverse && i_out_freq >= fwd_q) |=> fu_q)
    else $error("reached flag missing");
  reach_rev_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_dc_brake && i_reverse && rev_q != REV_SAME_CODE && i_out_freq < rev_q) |=> !fu_q)
    else $error("reverse level ignored");
  write_lock_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_extended_display_select != 8'h00) |=> $stable(fwd_q) && $stable(rev_q) && $stable(sens_q))
    else $error("setting changed while locked");
  sens_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    sens_q <= SENS_MAX) else $error("sensitivity out of range");
  up_band_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_dc_brake && i_out_freq == i_cmd_freq) |=> su_q) else $error("up flag missing");
  term_pos_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (sel_a_q == SEL_FREQ_REACHED && $stable(sel_a_q)) |=> term_a_q == $past(fu_q))
    else $error("terminal a not following reached flag");
  term_neg_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (sel_b_q == 8'(SEL_UP_TO_FREQ + SEL_NEG_OFFSET)) |=> term_b_q == !$past(su_q))
    else $error("terminal b not inverted");

  // ----------------------------------------
  // further checks
  // ----------------------------------------
  reach_below_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_reverse && i_out_freq < fwd_q) |=> !fu_q)
    else $error("reached flag below level");
  reach_same_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_dc_brake && i_reverse && rev_q == REV_SAME_CODE && i_out_freq >= fwd_q) |=> fu_q)
    else $error("forward level not used in reverse");
  reach_rev_hi_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_dc_brake && i_reverse && rev_q != REV_SAME_CODE && i_out_freq >= rev_q) |=> fu_q)
    else $error("reverse reached flag missing");
  up_none_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (sens_q == 7'h00 && i_out_freq != i_cmd_freq) |=> !su_q)
    else $error("up flag outside zero band");

  write_fwd_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_set_wr && i_extended_display_select == 8'h00 && i_set_sel == 2'h1
      && i_set_data <= LEVEL_MAX) |=> fwd_q == $past(i_set_data))
    else $error("forward level write lost");
  write_sens_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_set_wr && i_extended_display_select == 8'h00 && i_set_sel == 2'h0
      && i_set_data <= {9'h000, SENS_MAX}) |=> sens_q == $past(i_set_data[6:0]))
    else $error("sensitivity write lost");
  sens_refuse_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_set_sel == 2'h0 && i_set_data > {9'h000, SENS_MAX}) |=> $stable(sens_q))
    else $error("sensitivity out of range taken");
  level_refuse_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_set_data > LEVEL_MAX) |=> $stable(fwd_q) && $stable(rev_q))
    else $error("level out of range taken");
  rev_same_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_set_wr && i_extended_display_select == 8'h00 && i_set_sel == 2'h2
      && i_set_data == REV_SAME_CODE) |=> rev_q == REV_SAME_CODE)
    else $error("same-as-forward code lost");

  term_up_pos_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (sel_a_q == SEL_UP_TO_FREQ) |=> term_a_q == $past(su_q))
    else $error("terminal a not following up flag");
  term_fu_neg_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (sel_b_q == 8'(SEL_FREQ_REACHED + SEL_NEG_OFFSET)) |=> term_b_q == !$past(fu_q))
    else $error("terminal b not inverting reached flag");
  term_a_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (sel_a_q == 8'h00) |=> !term_a_q)
    else $error("terminal a conducts with no function");
  term_b_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (sel_b_q == 8'h00) |=> !term_b_q)
    else $error("terminal b conducts with no function");
endmodule
`default_nettype wire

// file: shared/freq_detect_pkg.sv
// constants and types for the output frequency detector
// assumes frequencies in 0.01 Hz units, percentages in whole percent
// Operation
// - up-to-frequency within sensitivity band of command
// - sensitivity 0 to 100 percent, default 10
// - code 1 positive, 101 negative up-to-frequency
// - reached flag when output at or above level
// - reverse level 9999 means use forward level
// - code 4 positive, 104 negative reached flag
// - both flags off during dc injection braking
// - compare frequency before slip compensation
// - settings writable only when display select zero; terminal select codes are registered every cycle regardless
// - codes 0-99 conduct when active, 100-199 not
package freq_detect_pkg;
  localparam int FREQ_W = 16;
  localparam logic [6:0] SENS_RESET = 7'h0a;
  localparam logic [6:0] SENS_MAX = 7'h64;
  localparam logic [15:0] FWD_LEVEL_RESET = 16'h0258;
  localparam logic [15:0] LEVEL_MAX = 16'h9c40;
  localparam logic [15:0] REV_SAME_CODE = 16'h270f;
  localparam logic [15:0] REV_LEVEL_RESET = 16'h270f;
  localparam logic [7:0] SEL_UP_TO_FREQ = 8'h01;
  localparam logic [7:0] SEL_FREQ_REACHED = 8'h04;
  localparam logic [7:0] SEL_NEG_OFFSET = 8'h64;
  localparam logic [7:0] SEL_NEG_MAX = 8'hc7;
  typedef enum logic [1:0] {
    SET_SENS,
    SET_FWD,
    SET_REV,
    SET_NONE
  } setting_sel_t;
endpackage

// file: shared/term_route_if.sv
// carries both detection flags to the terminal router
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface term_route_if;
  logic up_to_freq_flag;
  logic freq_reached_flag;
  modport source (output up_to_freq_flag, output freq_reached_flag);
  modport sink (input up_to_freq_flag, input freq_reached_flag);
endinterface
`default_nettype wire

// file: logic/term_router.sv
// routes a flag to one output terminal by selection code
// assumes code registered by the caller
`timescale 1ns/1ps
`default_nettype none
module term_router
  import freq_detect_pkg::*;
(
  input wire logic [7:0] i_code,
  term_route_if.sink flags,
  output logic o_conduct
);
  logic base_hit;
  logic neg;
  logic [7:0] base;
  always_comb begin
    neg = (i_code >= SEL_NEG_OFFSET) && (i_code <= SEL_NEG_MAX);
    base = neg ? 8'(i_code - SEL_NEG_OFFSET) : i_code;
    if (base == SEL_UP_TO_FREQ) begin
      base_hit = flags.up_to_freq_flag;
    end else if (base == SEL_FREQ_REACHED) begin
      base_hit = flags.freq_reached_flag;
    end else begin
      base_hit = 1'b0;
    end
    o_conduct = neg ? ~base_hit : base_hit;
  end
endmodule
`default_nettype wire

// file: verif/freq_gen_model.sv
// drive frequency generator model: output and commanded frequency
// assumes the bench has seeded $urandom before the first falling edge
`timescale 1ns/1ps
`default_nettype none
module freq_gen_model
  import freq_detect_pkg::*;
(
  input wire logic i_sys_clk,
  output logic [FREQ_W-1:0] o_out_freq,
  output logic [FREQ_W-1:0] o_cmd_freq,
  output logic o_reverse,
  output logic o_dc_brake
);
  int c;
  // out freq is the uncompensated value, near the command
  always @(negedge i_sys_clk) begin
    c = $urandom % 3000;
    o_cmd_freq <= 16'(c);
    o_out_freq <= 16'(c + ($urandom % 900));
    o_reverse <= 1'($urandom);
    o_dc_brake <= ($urandom % 8) == 0;
  end
endmodule
`default_nettype wire

// file: verif/output_frequency_detector_tb.sv
// self-checking bench for the output frequency detector
// assumes flags one cycle and terminals two cycles behind their inputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0d got %0d", nm, e, g); end end
module output_frequency_detector_tb;
  import freq_detect_pkg::*;
  logic clk = 0, rstn = 0, wr = 0;
  logic [FREQ_W-1:0] outf, cmdf;
  logic rev_dir, brk;
  logic [7:0] disp = 0, sa = 0, sb = 0;
  logic [1:0] sel = 0;
  logic [15:0] data = 0;
  logic [6:0] o_sens;
  logic [15:0] o_fwd, o_rev;
  logic o_su, o_fu, o_ta, o_tb;
  int err_count = 0, n_compared = 0, cyc = 0, diff, thr, go = 0;
  int sens, fwd, rev, su_e, fu_e, ta_e, tb_e, sa_q, sb_q;
  int codes[6] = '{1, 101, 4, 104, 0, 150};
  always #10 clk = ~clk;
  freq_gen_model gen (.i_sys_clk(clk), .o_out_freq(outf), .o_cmd_freq(cmdf),
    .o_reverse(rev_dir), .o_dc_brake(brk));
  output_frequency_detector uut (.i_sys_clk(clk), .i_resetn(rstn), .i_out_freq(outf),
    .i_cmd_freq(cmdf), .i_reverse(rev_dir), .i_dc_brake(brk),
    .i_extended_display_select(disp), .i_set_wr(wr), .i_set_sel(sel), .i_set_data(data),
    .i_terminal_select_a(sa), .i_terminal_select_b(sb), .o_up_to_freq_sensitivity(o_sens),
    .o_forward_detect_level(o_fwd), .o_reverse_detect_level(o_rev), .o_up_to_freq_flag(o_su),
    .o_freq_reached_flag(o_fu), .o_terminal_a(o_ta), .o_terminal_b(o_tb));
  function automatic int route(int code, int su, int fu);
    int act;
    act = (code % 100 == 1) ? su : (code % 100 == 4) ? fu : 0;
    return (code >= 100) ? !act : act;
  endfunction
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      {sens, fwd, rev} = {32'd10, 32'd600, 32'd9999};
      {su_e, fu_e, ta_e, tb_e, sa_q, sb_q} <= '0;
    end else begin
      ta_e <= route(sa_q, su_e, fu_e);
      tb_e <= route(sb_q, su_e, fu_e);
      sa_q <= sa;
      sb_q <= sb;
      diff = (outf > cmdf) ? outf - cmdf : cmdf - outf;
      thr = (rev_dir && rev != 9999) ? rev : fwd;
      su_e <= !brk && diff * 100 <= cmdf * sens;
      fu_e <= !brk && outf >= thr;
      if (wr && disp == 0) begin
        if (sel == 0 && data <= 100) sens <= data;
        if (sel == 1 && data <= 40000) fwd <= data;
        if (sel == 2 && data <= 40000) rev <= data;
      end
    end
  end
  // ----------------------------------------
  // checks and stimulus
  // ----------------------------------------
  always @(negedge clk) begin
    if (go) begin
      `CHK("sens", sens, o_sens)
      `CHK("fwd", fwd, o_fwd)
      `CHK("rev", rev, o_rev)
      `CHK("su", su_e, o_su)
      `CHK("fu", fu_e, o_fu)
      `CHK("term_a", ta_e, o_ta)
      `CHK("term_b", tb_e, o_tb)
      wr <= ($urandom % 4) == 0;
      sel <= 2'($urandom);
      disp <= ($urandom % 5 == 0) ? 8'($urandom % 3 + 1) : 8'h00;
      case ($urandom % 3)
        0: data <= 16'h270f;
        1: data <= 16'($urandom % 128);
        default: data <= 16'($urandom % 45000);
      endcase
      if ($urandom % 16 == 0) sa <= 8'(codes[$urandom % 6]);
      if ($urandom % 16 == 0) sb <= 8'(codes[$urandom % 6]);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(11753));
    repeat (10) @(negedge clk);
    rstn = 1;
    go = 1;
    repeat (3000) @(negedge clk);
    complete_run();
  end
endmodule
`default_nettype wire
